/* include/epi_pkg.sv */
/*
 * Constants, register map and types for the external pin interrupt block.
 * Assumes an APB master with 32-bit data and an 8-bit byte address; the
 * block sits on the device clock and the device reset.
 */
// Contract
// - Each of three pins is edge triggered, with its own detector.
// - Polarity bit 1 detects rising edges, 0 detects falling edges.
// - A detected edge of chosen polarity sets that pin's flag.
// - A pending flag is forwarded only while the pin's enable is set; the irq summary output ignores the enables.
// - An enabled pin interrupt wakes the core; enable must predate sleep entry.
// - After wake-up, branch to the vector only if global enable is set.
// - Pin-1 priority is bit 6, pin-2 priority bit 7, of third control register.
// - Pin 0 has no priority bit and is always high priority.
package epi_pkg;

	localparam int EPI_ADDR_W = 8;
	localparam int EPI_DATA_W = 32;
	localparam int EPI_NPINS = 3;
	localparam int EPI_SYNC_ARM_W = 3;

	// register byte offsets
	localparam logic [EPI_ADDR_W-1:0] EPI_OFF_CTRL2 = 8'h00;
	localparam logic [EPI_ADDR_W-1:0] EPI_OFF_CTRL3 = 8'h04;
	localparam logic [EPI_ADDR_W-1:0] EPI_OFF_FLAG = 8'h08;
	localparam logic [EPI_ADDR_W-1:0] EPI_OFF_MASK = 8'h0C;
	localparam logic [EPI_ADDR_W-1:0] EPI_OFF_PWR = 8'h10;

	// field positions
	localparam int EPI_POL_LSB = 0;
	localparam int EPI_EN_LSB = 0;
	localparam int EPI_FLAG_LSB = 0;
	localparam int EPI_MASK_LSB = 0;
	localparam int EPI_P1PRI_BIT = 6;
	localparam int EPI_P2PRI_BIT = 7;
	localparam int EPI_PWR_SLEEP_BIT = 0;
	localparam int EPI_PWR_GIE_BIT = 1;

	// pin indices
	localparam int EPI_PIN0 = 0;
	localparam int EPI_PIN1 = 1;
	localparam int EPI_PIN2 = 2;

	// reset values
	localparam logic [EPI_NPINS-1:0] EPI_POL_RST = 3'h7;
	localparam logic [EPI_NPINS-1:0] EPI_EN_RST = 3'h0;
	localparam logic [EPI_NPINS-1:0] EPI_FLAG_RST = 3'h0;
	localparam logic [EPI_NPINS-1:0] EPI_MASK_RST = 3'h0;
	localparam logic EPI_PRI_RST = 1'h1;
	localparam logic EPI_GIE_RST = 1'h0;
	localparam logic [EPI_SYNC_ARM_W-1:0] EPI_ARM_RST = 3'h0;
	localparam logic [EPI_DATA_W-1:0] EPI_RDATA_ZERO = 32'h0;

	// power state of the core as seen by this block
	typedef enum logic {
		EPI_PWR_RUN,
		EPI_PWR_SLEEP
	} epi_pwr_state_type;

endpackage

/* rtl/epi_edge_det.sv */
/*
 * One pin's synchroniser and edge detector.
 * Assumes the pin is asynchronous to pclk; produces a one-cycle pulse per
 * transition of the selected polarity.
 */
`timescale 1ns/1ps
module epi_edge_det
	import epi_pkg::*;
(
	input wire logic pclk, // device clock
	input wire logic presetn, // async reset, low
	input wire logic pin, // raw pin level
	input wire logic rise_sel, // 1 rising, 0 falling
	output logic edge_pulse // one-cycle edge event
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic [EPI_SYNC_ARM_W-1:0] arm_q;

	// two-flop synchroniser; meta_q feeds only sync_q
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// hold detection off until meta, sync and prev all hold real pin
	// samples (three edges), so a pin sitting high at reset gives no
	// false rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_q <= EPI_ARM_RST;
		end else if (!arm_q[EPI_SYNC_ARM_W-1]) begin
			arm_q <= {arm_q[EPI_SYNC_ARM_W-2:0], 1'b1};
		end
	end

	// compare two synchronised samples, never the metastable one
	always_comb begin
		if (rise_sel) begin
			edge_pulse = arm_q[EPI_SYNC_ARM_W-1] & sync_q & ~prev_q;
		end else begin
			edge_pulse = arm_q[EPI_SYNC_ARM_W-1] & ~sync_q & prev_q;
		end
	end

endmodule // epi_edge_det

/* rtl/epi_pin_irq.sv */
/*
 * External pin interrupt logic: three edge detectors, sticky flags with
 * enables and priority, APB register file, wake and vector signalling.
 * Assumes an APB master on pclk, pins asynchronous, and a core that
 * reads irq_hi/irq_lo as level requests and wake/vector as pulses.
 */
`timescale 1ns/1ps
module epi_pin_irq
	import epi_pkg::*;
(
	input wire logic pclk, // device clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [epi_pkg::EPI_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [epi_pkg::EPI_DATA_W-1:0] pwdata, // apb write data
	output logic [epi_pkg::EPI_DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped
	input wire logic ext_irq_pin0, // external pin 0
	input wire logic ext_irq_pin1, // external pin 1
	input wire logic ext_irq_pin2, // external pin 2
	output logic irq, // masked status level
	output logic irq_hi, // high-priority core request
	output logic irq_lo, // low-priority core request
	output logic core_wake, // wake pulse to core
	output logic core_vector, // branch-to-vector pulse
	output logic core_sleeping // core is in power managed mode
);
	import epi_pkg::*;

	// address match on the word, byte lanes ignored
	function automatic logic reg_hit(
		input logic [EPI_ADDR_W-1:0] addr,
		input logic [EPI_ADDR_W-1:0] off
	);
		reg_hit = (addr[EPI_ADDR_W-1:2] == off[EPI_ADDR_W-1:2]);
	endfunction

	// true when the address hits any implemented register
	function automatic logic addr_mapped(input logic [EPI_ADDR_W-1:0] addr);
		addr_mapped = reg_hit(addr, EPI_OFF_CTRL2) | reg_hit(addr, EPI_OFF_CTRL3)
			| reg_hit(addr, EPI_OFF_FLAG) | reg_hit(addr, EPI_OFF_MASK)
			| reg_hit(addr, EPI_OFF_PWR);
	endfunction

	// control state
	logic [EPI_NPINS-1:0] edge_polarity_select_q;
	logic [EPI_NPINS-1:0] pin_irq_enable_q;
	logic pin1_priority_bit_q;
	logic pin2_priority_bit_q;
	logic global_irq_enable_q;
	logic [EPI_NPINS-1:0] mask_q;

	// status state
	logic [EPI_NPINS-1:0] pin_irq_flag_q;
	logic [EPI_NPINS-1:0] pin_irq_flag_d;
	logic [EPI_NPINS-1:0] wake_en_q;
	epi_pwr_state_type pwr_q;

	// bus state
	logic pready_q;
	logic pslverr_q;
	logic [EPI_DATA_W-1:0] prdata_q;
	logic [EPI_DATA_W-1:0] rdata_d;

	// output flops
	logic irq_q;
	logic irq_hi_q;
	logic irq_lo_q;
	logic core_wake_q;
	logic core_vector_q;

	// derived terms
	logic [EPI_NPINS-1:0] pin_raw;
	logic [EPI_NPINS-1:0] edge_evt;
	logic [EPI_NPINS-1:0] pending;
	logic [EPI_NPINS-1:0] hi_sel;
	logic acc;
	logic wr;
	logic setup;
	logic wake_evt;

	assign pin_raw = {ext_irq_pin2, ext_irq_pin1, ext_irq_pin0};

	// one detector per pin, each with its own polarity
	for (genvar g = 0; g < EPI_NPINS; g++) begin : g_pin
		epi_edge_det u_det (
			.pclk(pclk),
			.presetn(presetn),
			.pin(pin_raw[g]),
			.rise_sel(edge_polarity_select_q[g]),
			.edge_pulse(edge_evt[g])
		);
	end

	// apb phases; a transfer lands on the edge where pready is seen high
	assign setup = psel & ~penable;
	assign acc = psel & penable & pready_q;
	assign wr = acc & pwrite;

	// answer one cycle after setup: no wait states beyond the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= psel & ~pready_q & (setup | penable);
		end
	end

	// error flag for addresses outside the map, valid with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= ~addr_mapped(paddr);
		end else if (acc) begin
			pslverr_q <= 1'b0;
		end
	end

	// read mux; unimplemented bits and unmapped addresses read zero
	always_comb begin
		rdata_d = EPI_RDATA_ZERO;
		if (reg_hit(paddr, EPI_OFF_CTRL2)) begin
			rdata_d[EPI_POL_LSB +: EPI_NPINS] = edge_polarity_select_q;
		end
		if (reg_hit(paddr, EPI_OFF_CTRL3)) begin
			rdata_d[EPI_EN_LSB +: EPI_NPINS] = pin_irq_enable_q;
			rdata_d[EPI_P1PRI_BIT] = pin1_priority_bit_q;
			rdata_d[EPI_P2PRI_BIT] = pin2_priority_bit_q;
		end
		if (reg_hit(paddr, EPI_OFF_FLAG)) begin
			rdata_d[EPI_FLAG_LSB +: EPI_NPINS] = pin_irq_flag_q;
		end
		if (reg_hit(paddr, EPI_OFF_MASK)) begin
			rdata_d[EPI_MASK_LSB +: EPI_NPINS] = mask_q;
		end
		if (reg_hit(paddr, EPI_OFF_PWR)) begin
			rdata_d[EPI_PWR_SLEEP_BIT] = (pwr_q == EPI_PWR_SLEEP);
			rdata_d[EPI_PWR_GIE_BIT] = global_irq_enable_q;
		end
	end

	// read data captured in setup, so it is stable through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= EPI_RDATA_ZERO;
		end else if (setup && !pwrite) begin
			prdata_q <= rdata_d;
		end else if (acc) begin
			prdata_q <= EPI_RDATA_ZERO;
		end
	end

	// polarity selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_polarity_select_q <= EPI_POL_RST;
		end else if (wr && reg_hit(paddr, EPI_OFF_CTRL2)) begin
			edge_polarity_select_q <= pwdata[EPI_POL_LSB +: EPI_NPINS];
		end
	end

	// enables and the two priority bits share the third control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_irq_enable_q <= EPI_EN_RST;
			pin1_priority_bit_q <= EPI_PRI_RST;
			pin2_priority_bit_q <= EPI_PRI_RST;
		end else if (wr && reg_hit(paddr, EPI_OFF_CTRL3)) begin
			pin_irq_enable_q <= pwdata[EPI_EN_LSB +: EPI_NPINS];
			pin1_priority_bit_q <= pwdata[EPI_P1PRI_BIT];
			pin2_priority_bit_q <= pwdata[EPI_P2PRI_BIT];
		end
	end

	// interrupt mask for the summary output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= EPI_MASK_RST;
		end else if (wr && reg_hit(paddr, EPI_OFF_MASK)) begin
			mask_q <= pwdata[EPI_MASK_LSB +: EPI_NPINS];
		end
	end

	// global enable lives in the power register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_irq_enable_q <= EPI_GIE_RST;
		end else if (wr && reg_hit(paddr, EPI_OFF_PWR)) begin
			global_irq_enable_q <= pwdata[EPI_PWR_GIE_BIT];
		end
	end

	// flags: write one to clear, but an edge in the same cycle wins
	always_comb begin
		pin_irq_flag_d = pin_irq_flag_q;
		if (wr && reg_hit(paddr, EPI_OFF_FLAG)) begin
			pin_irq_flag_d = pin_irq_flag_q & ~pwdata[EPI_FLAG_LSB +: EPI_NPINS];
		end
		pin_irq_flag_d = pin_irq_flag_d | edge_evt;
	end

	// flags hold until software clears them, whatever the enable does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_irq_flag_q <= EPI_FLAG_RST;
		end else begin
			pin_irq_flag_q <= pin_irq_flag_d;
		end
	end

	// a flag only counts as a request while its pin is enabled
	assign pending = pin_irq_flag_q & pin_irq_enable_q;

	// priority routing: pin 0 has no bit and is tied high
	always_comb begin
		hi_sel = '0;
		hi_sel[EPI_PIN0] = 1'b1;
		hi_sel[EPI_PIN1] = pin1_priority_bit_q;
		hi_sel[EPI_PIN2] = pin2_priority_bit_q;
	end

	// core requests need the global enable as well
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_hi_q <= 1'b0;
			irq_lo_q <= 1'b0;
		end else begin
			irq_hi_q <= global_irq_enable_q & |(pending & hi_sel);
			irq_lo_q <= global_irq_enable_q & |(pending & ~hi_sel);
		end
	end

	// summary line: any unmasked flag, independent of the enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(pin_irq_flag_q & mask_q);
		end
	end

	// wake only on pins whose enable was captured at sleep entry;
	// enabling a pin while asleep is too late to wake the core
	assign wake_evt = (pwr_q == EPI_PWR_SLEEP) & |(pin_irq_flag_q & wake_en_q);

	// power state; software enters sleep by writing the sleep bit to one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q <= EPI_PWR_RUN;
			wake_en_q <= EPI_EN_RST;
		end else begin
			case (pwr_q)
				EPI_PWR_RUN: begin
					if (wr && reg_hit(paddr, EPI_OFF_PWR) && pwdata[EPI_PWR_SLEEP_BIT]) begin
						pwr_q <= EPI_PWR_SLEEP;
						wake_en_q <= pin_irq_enable_q;
					end
				end
				EPI_PWR_SLEEP: begin
					if (wake_evt) begin
						pwr_q <= EPI_PWR_RUN;
						wake_en_q <= EPI_EN_RST;
					end
				end
				default: begin
					pwr_q <= EPI_PWR_RUN;
					wake_en_q <= EPI_EN_RST;
				end
			endcase
		end
	end

	// wake pulse, and a vector pulse alongside it only with global enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_wake_q <= 1'b0;
			core_vector_q <= 1'b0;
		end else begin
			core_wake_q <= wake_evt;
			core_vector_q <= wake_evt & global_irq_enable_q;
		end
	end

	// all outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign irq_hi = irq_hi_q;
	assign irq_lo = irq_lo_q;
	assign core_wake = core_wake_q;
	assign core_vector = core_vector_q;
	assign core_sleeping = (pwr_q == EPI_PWR_SLEEP);

endmodule // epi_pin_irq

/* tb/epi_asserts.sv */
/*
 * Port-level checker for the pin interrupt block.
 * Assumes binding onto epi_pin_irq, single clock pclk, async reset presetn.
 */
`timescale 1ns/1ps
module epi_asserts
	import epi_pkg::*;
(
	input wire logic pclk, // device clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pwrite, // apb direction
	input wire logic [epi_pkg::EPI_ADDR_W-1:0] paddr, // byte address
	input wire logic [epi_pkg::EPI_DATA_W-1:0] pwdata, // write data
	input wire logic [epi_pkg::EPI_DATA_W-1:0] prdata, // read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic core_wake, // wake pulse
	input wire logic core_vector, // vector pulse
	input wire logic core_sleeping // power managed
);
	// one clock domain, so share clock and reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_rdy1; pready |=> !pready; endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready held");
	property p_err; pslverr |-> pready && psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_rd0; !pready |-> prdata == '0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside access");
	// entry from run: the write edge moves the state flop, a wake needs one more edge
	property p_sleep;
		psel && penable && pready && pwrite && !core_sleeping && paddr == EPI_OFF_PWR
			&& pwdata[EPI_PWR_SLEEP_BIT] |=> core_sleeping;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	property p_wake; core_wake |-> !core_sleeping && $past(core_sleeping); endproperty
	a_wake: assert property (p_wake) else $error("wake while awake");
	property p_fall; $fell(core_sleeping) |-> core_wake; endproperty
	a_fall: assert property (p_fall) else $error("left sleep without wake");
	property p_pulse; core_wake |=> !core_wake; endproperty
	a_pulse: assert property (p_pulse) else $error("wake not a pulse");
	property p_vec; core_vector |-> core_wake; endproperty
	a_vec: assert property (p_vec) else $error("vector without wake");
endmodule // epi_asserts

bind epi_pin_irq epi_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .core_wake(core_wake), .core_vector(core_vector), .core_sleeping(core_sleeping));

/* tb/epi_pin_src.sv */
/*
 * External signal sources for the three interrupt pins.
 * Assumes the bench holds each level at least two clocks.
 */
`timescale 1ns/1ps
module epi_pin_src (
	input wire logic pclk, // device clock
	input wire logic [2:0] lvl, // requested levels
	output logic [2:0] pin // pin levels
);
	// pins move mid-cycle, on the falling edge, half a period from the sampling edge
	always @(negedge pclk) begin
		pin <= lvl;
	end
endmodule // epi_pin_src

/* tb/tb_top.sv */
/*
 * Self-checking bench for the pin interrupt block.
 * Assumes the designer's APB timing and register map from the package.
 */
`timescale 1ns/1ps
module tb_top;
	import epi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [EPI_ADDR_W-1:0] paddr;
	logic [EPI_DATA_W-1:0] pwdata, prdata, rd;
	logic pready, pslverr, irq, irq_hi, irq_lo, core_wake, core_vector, core_sleeping;
	logic [2:0] lvl, pin;
	int fail_count, compares, wakes, vecs;

	epi_pin_src src (.pclk(pclk), .lvl(lvl), .pin(pin));
	epi_pin_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_irq_pin0(pin[0]), .ext_irq_pin1(pin[1]), .ext_irq_pin2(pin[2]), .irq(irq),
		.irq_hi(irq_hi), .irq_lo(irq_lo), .core_wake(core_wake), .core_vector(core_vector),
		.core_sleeping(core_sleeping));

	task automatic final_report;
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer; waits on pready, no fixed latency assumed,
	// only the watchdog ends a wait that never answers
	task automatic rw(input logic w, input logic [EPI_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pins(input logic [2:0] v);
		lvl <= v;
		repeat (6) @(posedge pclk);
	endtask

	// clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// count wake and vector pulses seen by the core
	always @(posedge pclk) begin
		if (core_wake === 1'b1) begin
			wakes++;
			if (core_vector === 1'b1) vecs++;
		end
	end

	// hang guard, well above the expected 150 or so cycles
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		final_report;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lvl = 3'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rw(1'b0, EPI_OFF_CTRL2, 32'h0);
		chk("polarity", rd, 32'h7);
		rw(1'b0, EPI_OFF_CTRL3, 32'h0);
		chk("ctrl3", rd, 32'hC0);
		rw(1'b0, EPI_OFF_FLAG, 32'h0);
		chk("flags", rd, 32'h0);
		rw(1'b0, 8'h14, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("test reset values done");
		// pin 1 falling, others rising
		rw(1'b1, EPI_OFF_CTRL2, 32'h5);
		pins(3'h7);
		rw(1'b0, EPI_OFF_FLAG, 32'h0);
		chk("rise flags", rd, 32'h5);
		rw(1'b1, EPI_OFF_FLAG, 32'h5);
		repeat (4) @(posedge pclk);
		rw(1'b0, EPI_OFF_FLAG, 32'h0);
		chk("held level", rd, 32'h0);
		pins(3'h0);
		rw(1'b0, EPI_OFF_FLAG, 32'h0);
		chk("fall flag", rd, 32'h2);
		$display("test edges done");
		rw(1'b1, EPI_OFF_PWR, 32'h2);
		rw(1'b1, EPI_OFF_CTRL3, 32'h87);
		repeat (2) @(posedge pclk);
		chk("lo pin1", {irq_hi, irq_lo, irq}, 32'h2);
		rw(1'b1, EPI_OFF_MASK, 32'h2);
		pins(3'h7);
		chk("hi pin0 pin2", {irq_hi, irq_lo, irq}, 32'h7);
		rw(1'b0, EPI_OFF_FLAG, 32'h0);
		chk("sticky", rd, 32'h7);
		rw(1'b1, EPI_OFF_CTRL3, 32'h42);
		repeat (2) @(posedge pclk);
		chk("pin1 hi", {irq_hi, irq_lo}, 32'h2);
		rw(1'b1, EPI_OFF_CTRL3, 32'h0);
		repeat (2) @(posedge pclk);
		chk("disabled", {irq_hi, irq_lo}, 32'h0);
		rw(1'b1, EPI_OFF_FLAG, 32'h7);
		repeat (2) @(posedge pclk);
		chk("cleared", {29'h0, irq, irq_hi, irq_lo}, 32'h0);
		$display("test priority done");
		rw(1'b1, EPI_OFF_CTRL3, 32'h4);
		rw(1'b1, EPI_OFF_PWR, 32'h1);
		// the state flop moves at the write edge itself; look one edge later
		@(posedge pclk);
		chk("asleep", {31'h0, core_sleeping}, 32'h1);
		pins(3'h3);
		pins(3'h7);
		chk("wakes no gie", wakes, 32'h1);
		chk("vector no gie", vecs, 32'h0);
		rw(1'b1, EPI_OFF_FLAG, 32'h7);
		rw(1'b1, EPI_OFF_PWR, 32'h3);
		pins(3'h3);
		pins(3'h7);
		chk("wakes gie", wakes, 32'h2);
		chk("vector gie", vecs, 32'h1);
		rw(1'b1, EPI_OFF_FLAG, 32'h7);
		rw(1'b1, EPI_OFF_CTRL3, 32'h0);
		rw(1'b1, EPI_OFF_PWR, 32'h3);
		rw(1'b1, EPI_OFF_CTRL3, 32'h4);
		pins(3'h3);
		pins(3'h7);
		chk("late enable", {31'h0, core_sleeping}, 32'h1);
		chk("late wakes", wakes, 32'h2);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset sleep", {31'h0, core_sleeping}, 32'h0);
		// pins sit high through reset with rising polarity: no false edge may follow
		repeat (4) @(posedge pclk);
		rw(1'b0, EPI_OFF_FLAG, 32'h0);
		chk("no false edge", rd, 32'h0);
		$display("test sleep done");
		final_report;
	end
endmodule // tb_top
